// ### verilog/rtsa_defines.svh
// rtsa_defines.svh: offsets, bit positions and reset values for one
// receive subaddress control/status block.
// assumes a 32-bit Avalon-MM slave port with byte addresses.
`ifndef RTSA_DEFINES_SVH
`define RTSA_DEFINES_SVH

// register byte offsets
`define RTSA_OFS_CTRL 8'h00
`define RTSA_OFS_CFG 8'h04
`define RTSA_OFS_IRQ_EN 8'h08
`define RTSA_OFS_IRQ_ST 8'h0c
`define RTSA_OFS_SOFT_RESET 8'h10

// control word bits
`define RTSA_BIT_IRQ_ARM 13
`define RTSA_BIT_BUSY 12
`define RTSA_BIT_ACC 11
`define RTSA_BIT_BSEL 10
`define RTSA_BIT_BROADCAST_SEEN 9

// config register fields
`define RTSA_BIT_BDIS 0
`define RTSA_MODE_LSB 1
`define RTSA_MODE_MSB 2

// soft reset command bit
`define RTSA_BIT_SOFT_RESET 0

// reset values
`define RTSA_RST_CTRL 16'h0000
`define RTSA_RST_CFG 3'h0
`define RTSA_RST_IRQ 16'h0000

`endif

// ### verilog/rtsa_pkg.sv
// rtsa_pkg: types shared by the subaddress control/status block.
// assumes rtsa_defines.svh for all numeric constants.
package rtsa_pkg;

	// buffer organisation of the subaddress
	typedef enum logic [1:0] {
		RTSA_PING_PONG,
		RTSA_INDEXED,
		RTSA_CIRC_1,
		RTSA_CIRC_2
	} rtsa_mode_t;

	// message tracking states
	typedef enum logic [1:0] {
		RTSA_IDLE,
		RTSA_STORE,
		RTSA_DISCARD
	} rtsa_msg_t;

endpackage

// ### verilog/rtsa_flag.sv
// rtsa_flag: one sticky flag, set by hardware, cleared by a pulse.
// assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module rtsa_flag
	import rtsa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic set,
	input wire logic clr,
	output logic q
);

	// set wins so an event in the clearing cycle is kept
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= 1'b0;
		else if (ce)
		begin
			if (set)
				q <= 1'b1;
			else if (clr)
				q <= 1'b0;
		end
	end

endmodule

// ### verilog/rtsa_toggle.sv
// rtsa_toggle: buffer select bit that inverts on a pulse.
// assumes toggle and clear come from logic on the same clock.
`timescale 1ns/1ps
module rtsa_toggle
	import rtsa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic toggle,
	input wire logic clr,
	output logic q
);

	// soft clear has priority: a message ending with the reset is dropped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= 1'b0;
		else if (ce)
		begin
			if (clr)
				q <= 1'b0;
			else if (toggle)
				q <= ~q;
		end
	end

endmodule

// ### verilog/rtsa_top.sv
// rtsa_top: control and status of one receive subaddress of a 1553
// remote terminal, with an Avalon-MM register port for the host.
// assumes the protocol engine on the same clock delivers decoded
// command, word and end-of-message pulses; rst_n is the master reset.
`timescale 1ns/1ps
`include "rtsa_defines.svh"
module rtsa_top
	import rtsa_pkg::*;
#(
	parameter int DW = 16
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic cmd_stb,
	input wire logic cmd_broadcast_seen,
	input wire logic cmd_illegal,
	input wire logic word_stb,
	input wire logic [DW-1:0] word_data,
	input wire logic end_stb,
	input wire logic end_error,
	output logic cmd_valid,
	output logic resp_busy,
	output logic mem_we,
	output logic [DW-1:0] mem_wdata,
	output logic mem_use_b,
	output logic irq_n
);

	// bus handshake and decode
	logic ack_q;
	logic req;
	logic rd_cap;
	logic wr_take;
	logic hit_ctrl;
	logic hit_cfg;
	logic hit_en;
	logic hit_st;
	logic hit_soft_reset;

	// host-written state
	logic force_busy_q;
	logic broadcast_irq_arm_q;
	logic broadcast_disable_q;
	rtsa_mode_t mode_q;
	logic [15:0] irq_en_q;
	logic soft_reset;

	// reset image of the configuration register
	localparam logic [2:0] CFG_RST = `RTSA_RST_CFG;

	// device-maintained state
	logic block_accessed_flag;
	logic buffer_b_select;
	logic broadcast_seen;
	logic st_broadcast_seen;
	logic st_acc;
	rtsa_msg_t msg_q;
	logic broadcast_seen_q;
	logic busy_q;
	logic ok_end;
	logic done;
	logic [15:0] ctrl_word;
	logic [15:0] st_word;

	// one wait cycle per access, answer on the second edge
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_take = avs_write & ack_q;

	assign hit_ctrl = avs_address == `RTSA_OFS_CTRL;
	assign hit_cfg = avs_address == `RTSA_OFS_CFG;
	assign hit_en = avs_address == `RTSA_OFS_IRQ_EN;
	assign hit_st = avs_address == `RTSA_OFS_IRQ_ST;
	assign hit_soft_reset = avs_address == `RTSA_OFS_SOFT_RESET;

	// read side effects act at the capture edge, not the answer edge:
	// a flag set between the two would otherwise be cleared unseen,
	// while here set wins against the clear in that same cycle
	assign rd_cap = avs_read & ~ack_q;

	// ack toggles so back-to-back requests each take two cycles
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ack_q <= 1'b0;
		else if (ce)
			ack_q <= req & ~ack_q;
	end

	// control word as the host sees it
	always_comb
	begin
		ctrl_word = `RTSA_RST_CTRL;
		ctrl_word[`RTSA_BIT_IRQ_ARM] = broadcast_irq_arm_q;
		ctrl_word[`RTSA_BIT_BUSY] = force_busy_q;
		ctrl_word[`RTSA_BIT_ACC] = block_accessed_flag;
		ctrl_word[`RTSA_BIT_BSEL] = buffer_b_select;
		ctrl_word[`RTSA_BIT_BROADCAST_SEEN] = broadcast_seen;
	end

	// status register uses the control word bit positions
	always_comb
	begin
		st_word = `RTSA_RST_IRQ;
		st_word[`RTSA_BIT_IRQ_ARM] = st_broadcast_seen;
		st_word[`RTSA_BIT_ACC] = st_acc;
	end

	// read data captured in the wait cycle, unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			avs_readdata <= 32'h0000_0000;
		else if (ce && rd_cap)
		begin
			avs_readdata <= 32'h0000_0000;
			if (hit_ctrl)
				avs_readdata <= {16'h0000, ctrl_word};
			else if (hit_cfg)
				avs_readdata <= {29'h0000_0000, mode_q,
					broadcast_disable_q};
			else if (hit_en)
				avs_readdata <= {16'h0000, irq_en_q};
			else if (hit_st)
				avs_readdata <= {16'h0000, st_word};
		end
	end

	// host control bits of the control word; byte 1 holds them
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			force_busy_q <= 1'b0;
			broadcast_irq_arm_q <= 1'b0;
		end
		else if (ce && wr_take && hit_ctrl && avs_byteenable[1])
		begin
			force_busy_q <= avs_writedata[`RTSA_BIT_BUSY];
			broadcast_irq_arm_q <= avs_writedata[`RTSA_BIT_IRQ_ARM];
		end
	end

	// terminal configuration; soft reset leaves it alone
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			broadcast_disable_q <= CFG_RST[`RTSA_BIT_BDIS];
			mode_q <= rtsa_mode_t'(
				CFG_RST[`RTSA_MODE_MSB:`RTSA_MODE_LSB]);
		end
		else if (ce && wr_take && hit_cfg && avs_byteenable[0])
		begin
			broadcast_disable_q <= avs_writedata[`RTSA_BIT_BDIS];
			mode_q <= rtsa_mode_t'(
				avs_writedata[`RTSA_MODE_MSB:`RTSA_MODE_LSB]);
		end
	end

	// interrupt enable register, same layout as status
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_en_q <= `RTSA_RST_IRQ;
		else if (ce && wr_take && hit_en)
		begin
			if (avs_byteenable[0])
				irq_en_q[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				irq_en_q[15:8] <= avs_writedata[15:8];
		end
	end

	// soft reset is a self-clearing command, one cycle wide
	assign soft_reset = wr_take && hit_soft_reset && avs_byteenable[0] &&
		avs_writedata[`RTSA_BIT_SOFT_RESET];

	// message tracking; busy is sampled once at command time
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			msg_q <= RTSA_IDLE;
			broadcast_seen_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (ce)
		begin
			if (soft_reset)
			begin
				msg_q <= RTSA_IDLE;
				broadcast_seen_q <= 1'b0;
				busy_q <= 1'b0;
			end
			else
			begin
				unique case (msg_q)
					RTSA_IDLE:
					begin
						// address 31 is refused while broadcast is off
						if (cmd_stb && !cmd_illegal &&
							!(cmd_broadcast_seen && broadcast_disable_q))
						begin
							broadcast_seen_q <= cmd_broadcast_seen;
							busy_q <= force_busy_q;
							msg_q <= force_busy_q ? RTSA_DISCARD
								: RTSA_STORE;
						end
					end
					RTSA_STORE, RTSA_DISCARD:
					begin
						if (end_stb)
						begin
							msg_q <= RTSA_IDLE;
							busy_q <= 1'b0;
						end
					end
					// the unused code falls back to idle
					default:
						msg_q <= RTSA_IDLE;
				endcase
			end
		end
	end

	// command acceptance and busy answer toward the protocol engine
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_valid <= 1'b0;
			resp_busy <= 1'b0;
		end
		else if (ce)
		begin
			cmd_valid <= !soft_reset && msg_q == RTSA_IDLE && cmd_stb &&
				!cmd_illegal && !(cmd_broadcast_seen && broadcast_disable_q);
			resp_busy <= force_busy_q;
		end
	end

	// data words pass to memory only while storing; busy drops them
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_we <= 1'b0;
			mem_wdata <= '0;
		end
		else if (ce)
		begin
			mem_we <= word_stb && msg_q == RTSA_STORE;
			if (word_stb)
				mem_wdata <= word_data;
		end
	end

	// buffer select steers only in ping-pong mode
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mem_use_b <= 1'b0;
		else if (ce)
			mem_use_b <= mode_q == RTSA_PING_PONG &&
				buffer_b_select;
	end

	// message end: all flags take the same strobe
	// so a host read never catches half an update
	assign done = ce && end_stb && msg_q != RTSA_IDLE && !soft_reset;
	assign ok_end = done && !end_error && !busy_q;

	// accessed flag, cleared by reading the control word
	rtsa_flag u_acc (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.set(done),
		.clr(soft_reset || (rd_cap && hit_ctrl)),
		.q(block_accessed_flag)
	);

	// ping-pong buffer select; holds after error or busy
	rtsa_toggle u_bsel (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.toggle(ok_end && mode_q == RTSA_PING_PONG),
		.clr(soft_reset),
		.q(buffer_b_select)
	);

	// broadcast seen flag, only reset clears it
	rtsa_flag u_broadcast_seen (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.set(done && broadcast_seen_q),
		.clr(soft_reset),
		.q(broadcast_seen)
	);

	// sticky broadcast interrupt event, armed per subaddress
	rtsa_flag u_st_broadcast_seen (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.set(done && broadcast_seen_q && broadcast_irq_arm_q),
		.clr(soft_reset || (rd_cap && hit_st)),
		.q(st_broadcast_seen)
	);

	// sticky message-complete event
	rtsa_flag u_st_acc (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.set(done),
		.clr(soft_reset || (rd_cap && hit_st)),
		.q(st_acc)
	);

	// level interrupt, low while an enabled status bit is set
	// registered so the pin never glitches while flags settle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_n <= 1'b1;
		else if (ce)
			irq_n <= ~|(st_word & irq_en_q);
	end

endmodule

// ### dv/rtsa_chk.sv
// rtsa_chk: port-level assertions for rtsa_top.
// assumes one clock, async active-low reset; bound by the line below.
`timescale 1ns/1ps
module rtsa_chk
	import rtsa_pkg::*;
#(
	parameter int DW = 16
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic cmd_stb,
	input wire logic cmd_illegal,
	input wire logic word_stb,
	input wire logic [DW-1:0] word_data,
	input wire logic end_stb,
	input wire logic cmd_valid,
	input wire logic resp_busy,
	input wire logic mem_we,
	input wire logic [DW-1:0] mem_wdata,
	input wire logic mem_use_b,
	input wire logic irq_n
);
	logic open_q;
	logic busy_q;
	logic [2:0] ev_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// open message and its busy answer, taken when the command is accepted
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			open_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (end_stb)
		begin
			open_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (cmd_valid)
		begin
			open_q <= 1'b1;
			busy_q <= resp_busy;
		end
	end

	// cycles since a message end or a taken write; saturates at 7
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ev_q <= 3'h0;
		else if (end_stb || (avs_write && !avs_waitrequest))
			ev_q <= 3'h0;
		else if (ev_q != 3'h7)
			ev_q <= ev_q + 3'h1;
	end

	a_illegal_drop: assert property (
		cmd_stb && cmd_illegal |=> !cmd_valid)
		else $error("illegal command accepted");
	a_busy_discard: assert property (
		busy_q |-> !mem_we)
		else $error("word stored during busy message");
	a_word_store: assert property (
		word_stb && open_q && !busy_q |=>
		mem_we && mem_wdata == $past(word_data))
		else $error("word not stored");
	a_irq_clear: assert property (
		avs_read && !avs_waitrequest && avs_address == 8'h0c && !open_q
		|-> ##2 irq_n)
		else $error("irq stays after status read");
	a_irq_fall: assert property (
		$fell(irq_n) |-> ev_q <= 3'h3)
		else $error("irq without cause");
	a_use_b_move: assert property (
		$changed(mem_use_b) |-> ev_q <= 3'h3)
		else $error("buffer select moved without cause");
	a_busy_move: assert property (
		$changed(resp_busy) |-> ev_q <= 3'h3)
		else $error("busy answer moved without write");
	a_reset_state: assert property (
		$rose(rst_n) |-> !mem_use_b && irq_n && !resp_busy)
		else $error("bad state after reset");
	a_one_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
endmodule

bind rtsa_top rtsa_chk #(.DW(DW)) u_chk (
	.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .cmd_stb(cmd_stb),
	.cmd_illegal(cmd_illegal), .word_stb(word_stb),
	.word_data(word_data), .end_stb(end_stb), .cmd_valid(cmd_valid),
	.resp_busy(resp_busy), .mem_we(mem_we), .mem_wdata(mem_wdata),
	.mem_use_b(mem_use_b), .irq_n(irq_n)
);

// ### dv/rtsa_bc_model.sv
// rtsa_bc_model: bus controller side, issues receive messages.
// assumes the bench calls send between bus accesses, on the same clock.
`timescale 1ns/1ps
module rtsa_bc_model
	import rtsa_pkg::*;
#(
	parameter int DW = 16
)
(
	input wire logic clk,
	output logic cmd_stb,
	output logic cmd_broadcast_seen,
	output logic cmd_illegal,
	output logic word_stb,
	output logic [DW-1:0] word_data,
	output logic end_stb,
	output logic end_error
);
	// quiet lines at time zero
	initial
	begin
		cmd_stb = 1'b0;
		cmd_broadcast_seen = 1'b0;
		cmd_illegal = 1'b0;
		word_stb = 1'b0;
		word_data = '0;
		end_stb = 1'b0;
		end_error = 1'b0;
	end

	// command, n words, end; qualifiers flip once released so a stale
	// value is never mistaken for a live one
	task automatic send(input logic bc, input logic ill, input logic err,
		input int n);
		@(posedge clk);
		cmd_stb <= 1'b1;
		cmd_broadcast_seen <= bc;
		cmd_illegal <= ill;
		@(posedge clk);
		cmd_stb <= 1'b0;
		cmd_broadcast_seen <= ~bc;
		cmd_illegal <= ~ill;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			word_stb <= 1'b1;
			word_data <= DW'(32'h5a00 + i);
			@(posedge clk);
			word_stb <= 1'b0;
			word_data <= ~word_data;
		end
		@(posedge clk);
		end_stb <= 1'b1;
		end_error <= err;
		@(posedge clk);
		end_stb <= 1'b0;
		end_error <= ~err;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ### dv/testbench.sv
// testbench: drives rtsa_top over Avalon-MM and through the bus model.
// assumes a 250 MHz clock and the register map of rtsa_defines.svh.
`timescale 1ns/1ps
`include "rtsa_defines.svh"
module testbench
	import rtsa_pkg::*;
;
	logic clk, rst_n, ce, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_q;
	logic [3:0] avs_byteenable;
	logic cmd_stb, cmd_broadcast_seen, cmd_illegal, word_stb, end_stb, end_error;
	logic cmd_valid, resp_busy, mem_we, mem_use_b, irq_n;
	logic [15:0] word_data, mem_wdata;
	int error_cnt = 0;
	int check_count = 0;
	int cmd_cnt = 0;

	rtsa_top #(.DW(16)) u_dut (
		.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cmd_stb(cmd_stb), .cmd_broadcast_seen(cmd_broadcast_seen),
		.cmd_illegal(cmd_illegal), .word_stb(word_stb),
		.word_data(word_data), .end_stb(end_stb), .end_error(end_error),
		.cmd_valid(cmd_valid), .resp_busy(resp_busy), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .mem_use_b(mem_use_b), .irq_n(irq_n)
	);
	rtsa_bc_model #(.DW(16)) u_bc (
		.clk(clk), .cmd_stb(cmd_stb), .cmd_broadcast_seen(cmd_broadcast_seen),
		.cmd_illegal(cmd_illegal), .word_stb(word_stb),
		.word_data(word_data), .end_stb(end_stb), .end_error(end_error)
	);

	// 4 ns clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// accepted commands, one cmd_valid pulse each
	always @(posedge clk)
		if (cmd_valid === 1'b1)
			cmd_cnt <= cmd_cnt + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one access; request held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(rd_q, e);
	endtask

	// main sequence
	initial
	begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		ce = 1'b1;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rdc(`RTSA_OFS_CTRL, 32'h0);
		chk({31'h0, irq_n}, 32'h1);
		u_bc.send(1'b0, 1'b0, 1'b0, 2);
		chk({31'h0, mem_use_b}, 32'h1);
		rdc(`RTSA_OFS_CTRL, 32'h0c00);
		rdc(`RTSA_OFS_CTRL, 32'h0400);
		u_bc.send(1'b0, 1'b0, 1'b1, 1);
		rdc(`RTSA_OFS_CTRL, 32'h0c00);
		u_bc.send(1'b0, 1'b1, 1'b0, 1);
		rdc(`RTSA_OFS_CTRL, 32'h0400);
		wr(`RTSA_OFS_CTRL, 32'h1000);
		repeat (2) @(posedge clk);
		chk({31'h0, resp_busy}, 32'h1);
		u_bc.send(1'b0, 1'b0, 1'b0, 2);
		rdc(`RTSA_OFS_CTRL, 32'h1c00);
		wr(`RTSA_OFS_CTRL, 32'h2000);
		wr(`RTSA_OFS_IRQ_EN, 32'h2000);
		u_bc.send(1'b1, 1'b0, 1'b0, 1);
		chk({31'h0, irq_n}, 32'h0);
		rdc(`RTSA_OFS_CTRL, 32'h2a00);
		rdc(`RTSA_OFS_IRQ_ST, 32'h2800);
		repeat (2) @(posedge clk);
		chk({31'h0, irq_n}, 32'h1);
		u_bc.send(1'b0, 1'b0, 1'b0, 1);
		wr(`RTSA_OFS_SOFT_RESET, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, mem_use_b}, 32'h0);
		rdc(`RTSA_OFS_CTRL, 32'h2000);
		// a message while the clock enable is low leaves no trace
		ce <= 1'b0;
		u_bc.send(1'b0, 1'b0, 1'b0, 1);
		ce <= 1'b1;
		rdc(`RTSA_OFS_CTRL, 32'h2000);
		wr(`RTSA_OFS_CFG, 32'h1);
		u_bc.send(1'b1, 1'b0, 1'b0, 1);
		chk({31'h0, irq_n}, 32'h1);
		rdc(`RTSA_OFS_CTRL, 32'h2000);
		chk(cmd_cnt, 32'h5);
		wr(`RTSA_OFS_CFG, 32'h0);
		u_bc.send(1'b0, 1'b0, 1'b0, 1);
		wr(`RTSA_OFS_CFG, 32'h2);
		u_bc.send(1'b0, 1'b0, 1'b0, 1);
		chk({31'h0, mem_use_b}, 32'h0);
		rdc(`RTSA_OFS_CTRL, 32'h2c00);
		rdc(8'h20, 32'h0);
		u_bc.send(1'b1, 1'b0, 1'b0, 1);
		rdc(`RTSA_OFS_CTRL, 32'h2e00);
		// master reset in mid-run with flags raised
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rdc(`RTSA_OFS_CTRL, 32'h0);
		chk({31'h0, irq_n}, 32'h1);
		chk(cmd_cnt, 32'h8);
		stop_test();
	end

	// the tests need a few hundred cycles; 10000 means a hang
	initial
	begin
		#40000;
		error_cnt++;
		stop_test();
	end
endmodule
